// >>> bench/vrl_regs_asserts.sv
`timescale 1ns/100ps
`default_nettype none

// port checker of the register bank
module vrl_regs_asserts #(
	parameter logic [4:0] READ_REG_CODE = 5'h07
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// command port
	input wire logic cmdValid,
	input wire logic cmdWrite,
	input wire logic [7:0] cmdCode,
	input wire logic [15:0] cmdWrData,
	input wire logic cmdAck,
	input wire logic cmdErr,
	input wire logic [15:0] cmdRdData,
	input wire logic cmdLocked,
	// serial capture
	input wire logic serCmdValid,
	input wire logic [3:0] serCmdAddr,
	input wire logic [4:0] serCmdCode,
	input wire logic serCmdParity,
	input wire logic serCmdParityErr,
	input wire logic serCmdFrameErr,
	input wire logic [7:0] serCmdPayload
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	// host requests
	sequence s_rd(c);
		cmdValid && !cmdWrite && cmdCode == c;
	endsequence
	sequence s_wr(c);
		cmdValid && cmdWrite && cmdCode == c;
	endsequence
	// an accepted capture read back in the next cycle
	sequence s_cap_rd;
		serCmdValid && !(serCmdCode == READ_REG_CODE &&
			serCmdPayload inside {[8'h80:8'h82]}) ##1 s_rd(8'h72);
	endsequence

	a_ack_follows: assert property (cmdValid |=> cmdAck)
		else $error("no ack after command");
	a_ack_unasked: assert property (!cmdValid |=> !cmdAck)
		else $error("ack without command");
	a_err_with_ack: assert property (cmdErr |-> cmdAck)
		else $error("error without ack");
	a_vin_fixed_exp: assert property (
		cmdValid && !cmdWrite && cmdCode inside {8'h35, 8'h36, 8'h55, 8'h58}
		|=> cmdRdData[15:8] == 8'hE8)
		else $error("threshold upper byte wrong");
	a_ofs_fixed_exp: assert property (
		s_rd(8'h39) |=> cmdRdData[15:6] == 10'h3E0)
		else $error("offset upper bits wrong");
	a_cal_top_zero: assert property (
		cmdValid && !cmdWrite && cmdCode inside {8'h3A, 8'h3B, 8'h3C}
		|=> !cmdRdData[15])
		else $error("reserved calibration bit set");
	a_vin_wr_rd: assert property (
		s_wr(8'h35) ##0 !cmdLocked ##2 s_rd(8'h35)
		|=> cmdRdData == {8'hE8, $past(cmdWrData[7:0], 3)})
		else $error("rising threshold readback wrong");
	a_lock_refuse: assert property (
		cmdValid && cmdWrite && cmdLocked && cmdCode != 8'h51 |=> cmdErr)
		else $error("locked write accepted");
	a_pw_open: assert property (s_wr(8'h51) |=> !cmdErr)
		else $error("entered password write refused");
	a_cap_ro: assert property (
		cmdValid && cmdWrite && cmdCode inside {8'h72, 8'h73} |=> cmdErr)
		else $error("capture write accepted");
	a_cap_fields: assert property (s_cap_rd |=>
		cmdRdData == {4'h0, $past(serCmdAddr, 2), $past(serCmdFrameErr, 2),
		$past(serCmdParityErr, 2), $past(serCmdParity, 2),
		$past(serCmdCode, 2)})
		else $error("capture fields wrong");
endmodule : vrl_regs_asserts

bind vrl_regs vrl_regs_asserts #(.READ_REG_CODE(READ_REG_CODE)) chk_u (
	.ref_clk, .rst, .cmdValid, .cmdWrite, .cmdCode, .cmdWrData, .cmdAck,
	.cmdErr, .cmdRdData, .cmdLocked, .serCmdValid, .serCmdAddr, .serCmdCode,
	.serCmdParity, .serCmdParityErr, .serCmdFrameErr, .serCmdPayload
);

`default_nettype wire

// >>> bench/vrl_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none

// self-checking bench of the register bank
module vrl_regs_tb;
	logic ref_clk = 1'h0;
	logic rst = 1'h1;
	logic cmdValid = 1'h0;
	logic cmdWrite = 1'h0;
	logic [7:0] cmdCode = 8'h00;
	logic [15:0] cmdWrData = 16'h0000;
	logic nvmRestore = 1'h0;
	logic [7:0] nvmPassword = 8'h00;
	logic [7:0] vinSense = 8'h30;
	logic [1:0] activePhases = 2'h1;
	logic [10:0] iMonRaw = 11'h190;
	logic [7:0] serCurrentRaw = 8'h64;
	logic cmdAck, cmdErr, cmdLocked, serCmdValid, serCmdParity;
	logic serCmdParityErr, serCmdFrameErr;
	logic vinSupplyOk, vinOvFault, vinOvEvent, vinUvWarn;
	logic [3:0] serCmdAddr;
	logic [4:0] serCmdCode;
	logic [7:0] serCmdPayload, storedPassword, serCurrentReport;
	logic [10:0] iOutReport;
	logic [15:0] cmdRdData;
	logic [15:0] evCnt = 16'h0000;
	int num_errors = 0;
	int checked = 0;
	int cycles = 0;
	logic [7:0] rstCode [13] = '{8'h35, 8'h36, 8'h55, 8'h58, 8'h38, 8'h39,
		8'h3A, 8'h3B, 8'h3C, 8'h50, 8'h51, 8'h72, 8'h73};
	logic [15:0] rstVal [13] = '{16'hE828, 16'hE820, 16'hE8C0, 16'hE824,
		16'h8900, 16'hF800, 16'h0080, 16'h0080, 16'h0080, 16'h0000,
		16'h0000, 16'h0000, 16'h0000};
	// {input level, 0, supply ok, over-voltage, under-voltage warning}
	logic [11:0] monTab [8] = '{12'h304, 12'h244, 12'h235, 12'h1F1,
		12'h270, 12'h284, 12'hC16, 12'hC04};
	logic [7:0] serTab [3] = '{8'hC6, 8'h31, 8'hC9};

	vrl_regs dut_u (.ref_clk, .rst, .cmdValid, .cmdWrite, .cmdCode,
		.cmdWrData, .cmdAck, .cmdErr, .cmdRdData, .cmdLocked, .serCmdValid,
		.serCmdAddr, .serCmdCode, .serCmdParity, .serCmdParityErr,
		.serCmdFrameErr, .serCmdPayload, .nvmRestore, .nvmPassword,
		.storedPassword, .vinSense, .activePhases, .iMonRaw, .serCurrentRaw,
		.vinSupplyOk, .vinOvFault, .vinOvEvent, .vinUvWarn, .iOutReport,
		.serCurrentReport);

	vrl_ser_model ser_u (.ref_clk, .serCmdValid, .serCmdAddr,
		.serCmdFrameErr, .serCmdParityErr, .serCmdParity, .serCmdCode,
		.serCmdPayload);

	always #10 ref_clk = ~ref_clk;

	// event pulses counted; hang guard far above the 130-odd cycles used
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (!rst && vinOvEvent)
			evCnt <= evCnt + 16'h0001;
		if (cycles == 3000) begin
			num_errors++;
			wrap_up();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time,
				seen, exp);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick

	// one command; writes and unmapped reads return zero data
	task automatic access(input logic w, input logic [7:0] c,
		input logic [15:0] d, input logic [15:0] exp, input logic e);
		@(posedge ref_clk);
		cmdValid <= 1'h1;
		cmdWrite <= w;
		cmdCode <= c;
		cmdWrData <= d;
		@(posedge ref_clk);
		cmdValid <= 1'h0;
		#1;
		check({14'h0000, cmdAck, cmdErr}, {14'h0000, 1'h1, e});
		check(cmdRdData, w ? 16'h0000 : exp);
	endtask : access

	// serial command with the capture read in the very next cycle
	task automatic capture(input logic [19:0] cmd, input logic [19:0] exp);
		fork
			ser_u.send(cmd);
			begin
				@(posedge ref_clk);
				access(1'h0, 8'h72, 16'h0000, {4'h0, exp[19:8]}, 1'h0);
			end
		join
		access(1'h0, 8'h73, 16'h0000, {8'h00, exp[7:0]}, 1'h0);
	endtask : capture

	task automatic wrap_up();
		if (num_errors == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : wrap_up

	initial begin
		repeat (10) @(posedge ref_clk);
		rst <= 1'h0;
		foreach (rstCode[i])
			access(1'h0, rstCode[i], 16'h0000, rstVal[i], 1'h0);
		// hysteresis between turn-on and turn-off, then the two limits
		foreach (monTab[i]) begin
			@(posedge ref_clk);
			vinSense <= monTab[i][11:4];
			tick(2);
			check({13'h0000, vinSupplyOk, vinOvFault, vinUvWarn},
				{13'h0000, monTab[i][2:0]});
		end
		check(evCnt, 16'h0001);
		access(1'h1, 8'h35, 16'hFFFF, 16'h0000, 1'h0);
		access(1'h0, 8'h35, 16'h0000, 16'hE8FF, 1'h0);
		access(1'h1, 8'h39, 16'hFFFF, 16'h0000, 1'h0);
		access(1'h0, 8'h39, 16'h0000, 16'hF83F, 1'h0);
		access(1'h1, 8'h3A, 16'hFFFF, 16'h0000, 1'h0);
		access(1'h0, 8'h3A, 16'h0000, 16'h7FFF, 1'h0);
		access(1'h0, 8'h40, 16'h0000, 16'h0000, 1'h1);
		access(1'h1, 8'h72, 16'h1234, 16'h0000, 1'h1);
		access(1'h1, 8'h73, 16'h1234, 16'h0000, 1'h1);
		// report scaling for each k code, offset minus half an amp
		check({5'h00, iOutReport}, 16'h0062);
		access(1'h1, 8'h38, 16'h9100, 16'h0000, 1'h0);
		tick(2);
		check({5'h00, iOutReport}, 16'h00C6);
		access(1'h1, 8'h38, 16'h9900, 16'h0000, 1'h0);
		tick(2);
		check({5'h00, iOutReport}, 16'h018E);
		access(1'h1, 8'h3B, 16'h7F40, 16'h0000, 1'h0);
		access(1'h1, 8'h3C, 16'h02FF, 16'h0000, 1'h0);
		for (int p = 1; p < 4; p++) begin
			@(posedge ref_clk);
			activePhases <= 2'(p);
			tick(2);
			check({8'h00, serCurrentReport}, {8'h00, serTab[p-1]});
		end
		capture(20'h5AA5A, 20'h5AA5A);
		capture(20'h30782, 20'h5AA5A);
		capture(20'h3C783, 20'h3C783);
		// password lock, unlock, and restore from the store
		access(1'h1, 8'h50, 16'h00A5, 16'h0000, 1'h0);
		check({8'h00, storedPassword}, 16'h00A5);
		check({15'h0000, cmdLocked}, 16'h0001);
		access(1'h1, 8'h35, 16'h0011, 16'h0000, 1'h1);
		access(1'h0, 8'h35, 16'h0000, 16'hE8FF, 1'h0);
		access(1'h1, 8'h51, 16'h00A5, 16'h0000, 1'h0);
		access(1'h1, 8'h35, 16'h0011, 16'h0000, 1'h0);
		access(1'h0, 8'h35, 16'h0000, 16'hE811, 1'h0);
		access(1'h0, 8'h51, 16'h0000, 16'h00A5, 1'h0);
		@(posedge ref_clk);
		nvmRestore <= 1'h1;
		nvmPassword <= 8'h3C;
		@(posedge ref_clk);
		nvmRestore <= 1'h0;
		tick(1);
		check({8'h00, storedPassword}, 16'h003C);
		check({15'h0000, cmdLocked}, 16'h0001);
		access(1'h1, 8'h51, 16'h003C, 16'h0000, 1'h0);
		check({15'h0000, cmdLocked}, 16'h0000);
		wrap_up();
	end
endmodule : vrl_regs_tb

`default_nettype wire

// >>> bench/vrl_ser_model.sv
`timescale 1ns/100ps
`default_nettype none

// far end of the serial voltage link, handing decoded commands over
module vrl_ser_model (
	// clock
	input wire logic ref_clk,
	// decoded command
	output var logic serCmdValid,
	output wire logic [3:0] serCmdAddr,
	output wire logic serCmdFrameErr,
	output wire logic serCmdParityErr,
	output wire logic serCmdParity,
	output wire logic [4:0] serCmdCode,
	output wire logic [7:0] serCmdPayload
);
	logic [19:0] word = 20'h00000;

	assign {serCmdAddr, serCmdFrameErr, serCmdParityErr, serCmdParity,
		serCmdCode, serCmdPayload} = word;

	initial serCmdValid = 1'h0;

	// one cycle of valid; the fields then turn to their inverse so that
	// a late sample picks up a wrong word
	task automatic send(input logic [19:0] cmd);
		@(posedge ref_clk);
		serCmdValid <= 1'h1;
		word <= cmd;
		@(posedge ref_clk);
		serCmdValid <= 1'h0;
		word <= ~cmd;
	endtask : send
endmodule : vrl_ser_model

`default_nettype wire

// >>> design/vrl_cal_if.sv
`timescale 1ns/100ps
`default_nettype none

// settings handed from the register bank to the monitor and report logic
interface vrl_cal_if;
	logic [7:0] vinRise;
	logic [7:0] vinFall;
	logic [7:0] vinOvLimit;
	logic [7:0] vinUvLimit;
	logic [4:0] iGainK;
	logic [10:0] iGain;
	logic [5:0] iOfs;
	logic [7:0] serGain;
	logic [6:0] serOfs;

	modport regs (
		output vinRise, vinFall, vinOvLimit, vinUvLimit,
		output iGainK, iGain, iOfs, serGain, serOfs
	);
	modport mon (
		input vinRise, vinFall, vinOvLimit, vinUvLimit
	);
	modport rep (
		input iGainK, iGain, iOfs, serGain, serOfs
	);
endinterface : vrl_cal_if

`default_nettype wire

// >>> design/vrl_consts.svh
// Operation
// - threshold registers read exponent 11101 in bits 15:11; writes there are dropped.
// - reserved bits drop writes and always read back as zero.
// - rising-threshold low byte is the turn-on level, 0.125 V per count.
// - falling-threshold low byte is the turn-off level, 0.125 V per count.
// - input above over-voltage limit raises the protection trigger.
// - input below under-voltage warning limit raises the low-input warning.
// - gain bits 15:11 select k: 10001 is 1, 10010 is 2, 10011 is 4.
// - gain bits 10:0 multiply the host output-current report.
// - current offset register reads exponent 11111 in bits 15:11.
// - six-bit signed offset, 0.5 A per count, added to host report; resets zero.
// - seven-bit signed offset, bit 14 sign, added to serial current report.
// - eight-bit gain scales serial current report; resets to 128.
// - three gain/offset sets, picked by one, two or three active phases.
// - other registers accept writes only while entered equals stored password.
// - stored password goes to nonvolatile store; entered password never does.
// - capture every serial command except reads of the capture locations.
// - capture register bits 11:8 hold the last command's address.
// - low capture byte: frame error, parity error, parity, five-bit code.
// - last command's payload byte sits in its own read-only register.
`ifndef VRL_CONSTS_SVH
`define VRL_CONSTS_SVH

// command codes of the register bank
`define VRL_CMD_VIN_RISE 8'h35
`define VRL_CMD_VIN_FALL 8'h36
`define VRL_CMD_IOUT_GAIN 8'h38
`define VRL_CMD_IOUT_OFS 8'h39
`define VRL_CMD_SER_CAL1 8'h3A
`define VRL_CMD_SER_CAL2 8'h3B
`define VRL_CMD_SER_CAL3 8'h3C
`define VRL_CMD_SYS_PW 8'h50
`define VRL_CMD_IN_PW 8'h51
`define VRL_CMD_VIN_OV 8'h55
`define VRL_CMD_VIN_UV 8'h58
`define VRL_CMD_CAP_ADDR 8'h72
`define VRL_CMD_CAP_PAYLOAD 8'h73

// fixed exponents and k codes
`define VRL_EXP_VIN 5'h1D
`define VRL_EXP_IOFS 5'h1F
`define VRL_K1_CODE 5'h11
`define VRL_K2_CODE 5'h12
`define VRL_K4_CODE 5'h13

// reset values
`define VRL_VIN_RISE_RST 8'h28
`define VRL_VIN_FALL_RST 8'h20
`define VRL_VIN_OV_RST 8'hC0
`define VRL_VIN_UV_RST 8'h24
`define VRL_IOUT_GAIN_RST 11'h100
`define VRL_IOUT_OFS_RST 6'h00
`define VRL_SER_GAIN_RST 8'h80
`define VRL_SER_OFS_RST 7'h00
`define VRL_PW_RST 8'h00

// serial capture window and scaling
`define VRL_CAP_LOC_LO 8'h80
`define VRL_CAP_LOC_HI 8'h82
`define VRL_READ_REG_CODE 5'h07
`define VRL_IOUT_SHIFT 10
`define VRL_SER_SHIFT 7
`define VRL_IOUT_MAX 11'h7FF
`define VRL_SER_MAX 8'hFF

`endif

// >>> design/vrl_current_report.sv
`timescale 1ns/100ps
`default_nettype none
`include "vrl_consts.svh"

module vrl_current_report (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// settings
	vrl_cal_if.rep cal,
	// raw current samples
	input wire logic [10:0] iMonRaw,
	input wire logic [7:0] serCurrentRaw,
	// calibrated reports
	output logic [10:0] iOutReport,
	output logic [7:0] serCurrentReport
);

	vrl_pkg::vrl_rep_state_t q, d;
	logic [21:0] iProd;
	logic [15:0] serProd;
	logic [4:0] iShift;
	logic signed [23:0] iSum;
	logic signed [23:0] serSum;

	// saturate a signed sum into 0..max, so a negative offset never wraps
	function automatic logic [10:0] clampTo(input logic signed [23:0] v,
		input logic [10:0] max);
		if (v < 0) begin
			clampTo = 11'h000;
		end else if (v > $signed({13'h0000, max})) begin
			clampTo = max;
		end else begin
			clampTo = v[10:0];
		end
	endfunction : clampTo

	// larger k means a smaller programmed gain, so shift less
	always_comb begin
		unique case (cal.iGainK)
			`VRL_K2_CODE: iShift = 5'(`VRL_IOUT_SHIFT - 1);
			`VRL_K4_CODE: iShift = 5'(`VRL_IOUT_SHIFT - 2);
			default: iShift = 5'(`VRL_IOUT_SHIFT);
		endcase
	end

	// host report: gain, then offset in 0.5 A steps on a 0.25 A scale
	assign iProd = 22'(iMonRaw) * 22'(cal.iGain);
	assign iSum = $signed({2'b00, iProd >> iShift})
		+ ($signed({{18{cal.iOfs[5]}}, cal.iOfs}) <<< 1);

	// serial report: gain of 128 is unity, offset added directly
	assign serProd = 16'(serCurrentRaw) * 16'(cal.serGain);
	assign serSum = $signed({8'h00, serProd >> `VRL_SER_SHIFT})
		+ $signed({{17{cal.serOfs[6]}}, cal.serOfs});

	always_comb begin
		d = q;
		d.iOut = clampTo(iSum, `VRL_IOUT_MAX);
		d.serCur = 8'(clampTo(serSum, {3'b000, `VRL_SER_MAX}));
	end

	// state register
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign iOutReport = q.iOut;
	assign serCurrentReport = q.serCur;

endmodule : vrl_current_report

`default_nettype wire

// >>> design/vrl_pkg.sv
package vrl_pkg;

	// input supply state, one-hot
	typedef enum logic [1:0] {
		VRL_SUPPLY_OFF = 2'b01,
		VRL_SUPPLY_ON = 2'b10
	} vrl_supply_t;

	// register bank state
	typedef struct packed {
		logic [7:0] vinRise;
		logic [7:0] vinFall;
		logic [7:0] vinOvLimit;
		logic [7:0] vinUvLimit;
		logic [4:0] iGainK;
		logic [10:0] iGain;
		logic [5:0] iOfs;
		logic [2:0][7:0] serGain;
		logic [2:0][6:0] serOfs;
		logic [7:0] sysPw;
		logic [7:0] inPw;
		logic [3:0] capAddr;
		logic [7:0] capFlags;
		logic [7:0] capPayload;
		logic [15:0] rdData;
		logic ack;
		logic err;
	} vrl_regs_state_t;

	// input voltage monitor state
	typedef struct packed {
		vrl_supply_t supply;
		logic ovFault;
		logic ovEvent;
		logic uvWarn;
	} vrl_mon_state_t;

	// current report state
	typedef struct packed {
		logic [10:0] iOut;
		logic [7:0] serCur;
	} vrl_rep_state_t;

endpackage : vrl_pkg

// >>> design/vrl_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "vrl_consts.svh"

module vrl_regs #(
	parameter logic [4:0] READ_REG_CODE = `VRL_READ_REG_CODE
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// command port from the bus protocol layer
	input wire logic cmdValid,
	input wire logic cmdWrite,
	input wire logic [7:0] cmdCode,
	input wire logic [15:0] cmdWrData,
	output logic cmdAck,
	output logic cmdErr,
	output logic [15:0] cmdRdData,
	output logic cmdLocked,
	// received serial link command
	input wire logic serCmdValid,
	input wire logic [3:0] serCmdAddr,
	input wire logic [4:0] serCmdCode,
	input wire logic serCmdParity,
	input wire logic serCmdParityErr,
	input wire logic serCmdFrameErr,
	input wire logic [7:0] serCmdPayload,
	// nonvolatile store of the system password
	input wire logic nvmRestore,
	input wire logic [7:0] nvmPassword,
	output logic [7:0] storedPassword,
	// sensed quantities
	input wire logic [7:0] vinSense,
	input wire logic [1:0] activePhases,
	input wire logic [10:0] iMonRaw,
	input wire logic [7:0] serCurrentRaw,
	// results
	output logic vinSupplyOk,
	output logic vinOvFault,
	output logic vinOvEvent,
	output logic vinUvWarn,
	output logic [10:0] iOutReport,
	output logic [7:0] serCurrentReport
);

	localparam vrl_pkg::vrl_regs_state_t RESET_STATE = '{
		vinRise: `VRL_VIN_RISE_RST,
		vinFall: `VRL_VIN_FALL_RST,
		vinOvLimit: `VRL_VIN_OV_RST,
		vinUvLimit: `VRL_VIN_UV_RST,
		iGainK: `VRL_K1_CODE,
		iGain: `VRL_IOUT_GAIN_RST,
		iOfs: `VRL_IOUT_OFS_RST,
		serGain: {3{`VRL_SER_GAIN_RST}},
		serOfs: {3{`VRL_SER_OFS_RST}},
		sysPw: `VRL_PW_RST,
		inPw: `VRL_PW_RST,
		capAddr: 4'h0,
		capFlags: 8'h00,
		capPayload: 8'h00,
		rdData: 16'h0000,
		ack: 1'b0,
		err: 1'b0
	};

	vrl_pkg::vrl_regs_state_t q, d;
	vrl_cal_if cal ();
	logic unlocked;
	logic capTake;
	logic [1:0] phaseSet;

	// linear word with fixed exponent; bits 10:8 are reserved zero
	function automatic logic [15:0] linearWord(input logic [4:0] exponent,
		input logic [7:0] mant);
		linearWord = {exponent, 3'b000, mant};
	endfunction : linearWord

	// one serial cal word: bit 15 reserved, offset 14:8, gain 7:0
	function automatic logic [15:0] serWord(input logic [6:0] ofs,
		input logic [7:0] gain);
		serWord = {1'b0, ofs, gain};
	endfunction : serWord

	// a mismatched entered password locks all writes but its own
	assign unlocked = q.inPw == q.sysPw;

	// reads of the capture locations must not overwrite what they read
	assign capTake = serCmdValid
		&& !(serCmdCode == READ_REG_CODE
		&& serCmdPayload >= `VRL_CAP_LOC_LO
		&& serCmdPayload <= `VRL_CAP_LOC_HI);

	// zero phases is treated like one, the safest set
	assign phaseSet = (activePhases == 2'd0) ? 2'd0 : activePhases - 2'd1;

	// register bank next state
	always_comb begin
		d = q;
		d.ack = 1'b0;
		d.err = 1'b0;
		if (cmdValid) begin
			d.ack = 1'b1;
			d.rdData = 16'h0000;
			unique case (cmdCode)
				`VRL_CMD_VIN_RISE: d.rdData = linearWord(`VRL_EXP_VIN, q.vinRise);
				`VRL_CMD_VIN_FALL: d.rdData = linearWord(`VRL_EXP_VIN, q.vinFall);
				`VRL_CMD_VIN_OV: d.rdData = linearWord(`VRL_EXP_VIN, q.vinOvLimit);
				`VRL_CMD_VIN_UV: d.rdData = linearWord(`VRL_EXP_VIN, q.vinUvLimit);
				`VRL_CMD_IOUT_GAIN: d.rdData = {q.iGainK, q.iGain};
				`VRL_CMD_IOUT_OFS: d.rdData = {`VRL_EXP_IOFS, 5'h00, q.iOfs};
				`VRL_CMD_SER_CAL1: d.rdData = serWord(q.serOfs[0], q.serGain[0]);
				`VRL_CMD_SER_CAL2: d.rdData = serWord(q.serOfs[1], q.serGain[1]);
				`VRL_CMD_SER_CAL3: d.rdData = serWord(q.serOfs[2], q.serGain[2]);
				`VRL_CMD_SYS_PW: d.rdData = {8'h00, q.sysPw};
				`VRL_CMD_IN_PW: d.rdData = {8'h00, q.inPw};
				`VRL_CMD_CAP_ADDR: d.rdData = {4'h0, q.capAddr, q.capFlags};
				`VRL_CMD_CAP_PAYLOAD: d.rdData = {8'h00, q.capPayload};
				default: d.err = 1'b1;
			endcase
			if (cmdWrite) begin
				d.rdData = 16'h0000;
				if (cmdCode == `VRL_CMD_IN_PW) begin
					d.inPw = cmdWrData[7:0];
				end else if (!unlocked) begin
					d.err = 1'b1;
				end else begin
					unique case (cmdCode)
						`VRL_CMD_VIN_RISE: d.vinRise = cmdWrData[7:0];
						`VRL_CMD_VIN_FALL: d.vinFall = cmdWrData[7:0];
						`VRL_CMD_VIN_OV: d.vinOvLimit = cmdWrData[7:0];
						`VRL_CMD_VIN_UV: d.vinUvLimit = cmdWrData[7:0];
						`VRL_CMD_IOUT_GAIN: begin
							d.iGainK = cmdWrData[15:11];
							d.iGain = cmdWrData[10:0];
						end
						`VRL_CMD_IOUT_OFS: d.iOfs = cmdWrData[5:0];
						`VRL_CMD_SER_CAL1: begin
							d.serOfs[0] = cmdWrData[14:8];
							d.serGain[0] = cmdWrData[7:0];
						end
						`VRL_CMD_SER_CAL2: begin
							d.serOfs[1] = cmdWrData[14:8];
							d.serGain[1] = cmdWrData[7:0];
						end
						`VRL_CMD_SER_CAL3: begin
							d.serOfs[2] = cmdWrData[14:8];
							d.serGain[2] = cmdWrData[7:0];
						end
						`VRL_CMD_SYS_PW: d.sysPw = cmdWrData[7:0];
						default: d.err = 1'b1; // read-only or unmapped
					endcase
				end
			end
		end
		// a restore from the store overrides a host write in the same cycle
		if (nvmRestore) begin
			d.sysPw = nvmPassword;
		end
		if (capTake) begin
			d.capAddr = serCmdAddr;
			d.capFlags = {serCmdFrameErr, serCmdParityErr, serCmdParity,
				serCmdCode};
			d.capPayload = serCmdPayload;
		end
	end

	// state register
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			q <= RESET_STATE;
		end else begin
			q <= d;
		end
	end

	// settings for the monitor and report logic
	assign cal.vinRise = q.vinRise;
	assign cal.vinFall = q.vinFall;
	assign cal.vinOvLimit = q.vinOvLimit;
	assign cal.vinUvLimit = q.vinUvLimit;
	assign cal.iGainK = q.iGainK;
	assign cal.iGain = q.iGain;
	assign cal.iOfs = q.iOfs;
	assign cal.serGain = q.serGain[phaseSet];
	assign cal.serOfs = q.serOfs[phaseSet];

	// outputs of the bank
	assign cmdAck = q.ack;
	assign cmdErr = q.err;
	assign cmdRdData = q.rdData;
	assign cmdLocked = !unlocked;
	assign storedPassword = q.sysPw;

	vrl_vin_monitor u_mon (
		.ref_clk(ref_clk),
		.rst(rst),
		.cal(cal.mon),
		.vinSense(vinSense),
		.vinSupplyOk(vinSupplyOk),
		.vinOvFault(vinOvFault),
		.vinOvEvent(vinOvEvent),
		.vinUvWarn(vinUvWarn)
	);

	vrl_current_report u_rep (
		.ref_clk(ref_clk),
		.rst(rst),
		.cal(cal.rep),
		.iMonRaw(iMonRaw),
		.serCurrentRaw(serCurrentRaw),
		.iOutReport(iOutReport),
		.serCurrentReport(serCurrentReport)
	);

endmodule : vrl_regs

`default_nettype wire

// >>> design/vrl_vin_monitor.sv
`timescale 1ns/100ps
`default_nettype none
`include "vrl_consts.svh"

module vrl_vin_monitor (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// settings
	vrl_cal_if.mon cal,
	// sensed input voltage, 0.125 V per count
	input wire logic [7:0] vinSense,
	// results
	output logic vinSupplyOk,
	output logic vinOvFault,
	output logic vinOvEvent,
	output logic vinUvWarn
);

	vrl_pkg::vrl_mon_state_t q, d;

	// hysteresis between the two thresholds keeps the supply state quiet
	always_comb begin
		d = q;
		unique case (q.supply)
			vrl_pkg::VRL_SUPPLY_OFF: begin
				if (vinSense >= cal.vinRise) begin
					d.supply = vrl_pkg::VRL_SUPPLY_ON;
				end
			end
			vrl_pkg::VRL_SUPPLY_ON: begin
				if (vinSense < cal.vinFall) begin
					d.supply = vrl_pkg::VRL_SUPPLY_OFF;
				end
			end
		endcase
		d.ovFault = vinSense > cal.vinOvLimit;
		d.ovEvent = d.ovFault && !q.ovFault;
		d.uvWarn = vinSense < cal.vinUvLimit;
	end

	// state register
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			q <= '{supply: vrl_pkg::VRL_SUPPLY_OFF, default: 1'b0};
		end else begin
			q <= d;
		end
	end

	assign vinSupplyOk = q.supply == vrl_pkg::VRL_SUPPLY_ON;
	assign vinOvFault = q.ovFault;
	assign vinOvEvent = q.ovEvent;
	assign vinUvWarn = q.uvWarn;

endmodule : vrl_vin_monitor

`default_nettype wire
